// file: design/mpps_top.sv
// Phase sequencer: channel count, interleave timing, low-power drop and parking.
`timescale 1ns/100ps

// How it works
// (R1) With no phase pin strapped high and the low-power input high at configuration, the sequencer runs all four channels.
// (R2) Four channels fire in order 1-2-3-4, each a quarter period after the one before.
// (R3) Phase pin 4 strapped high gives three channels 1-2-3 spaced a third of a period.
// (R4) Phase pin 3 strapped high gives two channels, channel 2 half a period after channel 1.
// (R5) Phase pin 2 strapped high gives channel 1 alone with all other pins left undriven.
// (R6) Low-power input low at configuration gives channel 1 alone or channels 1 and 3 (1 and 2 with two channels strapped).
// (R7) The switching cycle is a fixed-length period counter shared by all channels.
// (R8) While low-power is asserted, the two straps choose one or two remaining phases.
// (R9) Releasing low-power restores all configured phases to normal operation.
// (R10) Dropped phases are parked mid-level if uncoupled and driven low if coupled.
// (R11) Leading and trailing edges move independently; steady state is trailing-edge.
// (R12) A load-step input turns all active phases on together.
// (R13) Outputs park at mid level in start-up delay, uncoupled phase shedding and faults.
// (R14) The two program straps feed the low-power phase-drop decode.
// (R15) Re-added phases wait for the period boundary so spacing is rebuilt evenly.
// (R16) Phase and low-power straps are sampled once at configuration and strapped pins are never driven.
module mpps_top #(
  parameter int P_PERIOD   = mpps_pkg::PERIOD_CYC,
  parameter int P_SS_DELAY = mpps_pkg::SS_DELAY_CYC,
  parameter int P_CW       = 16
) (
  // Clock, reset and enable.
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst,
  input  wire logic            i_clk_en,
  // Pins sampled through synchronisers.
  input  wire logic            i_low_power_request_n,
  input  wire logic            i_freq_program_strap,
  input  wire logic            i_ss_program_strap,
  input  wire logic [3:0]      i_phase_pin,
  input  wire logic            i_enable_main_rail,
  input  wire logic            i_enable_term_rail,
  input  wire logic            i_por_ok,
  input  wire logic            i_vcode_valid,
  input  wire logic            i_fault,
  input  wire logic            i_load_step,
  // Modulator edges from same-clock loop logic.
  input  wire logic [P_CW-1:0] i_duty,
  input  wire logic [P_CW-1:0] i_lead,
  // Phase pins and status.
  output logic      [3:0]      o_phase_out,
  output logic      [3:0]      o_phase_oe,
  output logic      [3:0]      o_phase_park,
  output logic      [3:0]      o_active_mask
);

  localparam logic [P_CW-1:0] PER   = P_CW'(P_PERIOD);
  localparam logic [P_CW-1:0] LAST  = P_CW'(P_PERIOD - 1);
  localparam logic [P_CW-1:0] SLOT2 = P_CW'(P_PERIOD / 2);
  localparam logic [P_CW-1:0] SLOT3 = P_CW'(P_PERIOD / 3);
  localparam logic [P_CW-1:0] SLOT4 = P_CW'(P_PERIOD / 4);
  localparam logic [31:0]     DLAST = 32'(P_SS_DELAY - 1);

  logic [mpps_pkg::SYNC_W-1:0] s;
  mpps_pkg::mpps_state_type    st_q;
  logic [31:0]                 dly_q;
  logic [P_CW-1:0]             cnt_q;
  logic [3:0]                  strap_q;
  logic                        lp_strap_q;
  logic [3:0]                  cfg_mask_q;
  logic [3:0]                  run_mask_q;
  logic                        op_w;
  logic                        wrap;
  logic [1:0]                  code_w;
  logic [3:0]                  cfg_w;
  logic [3:0]                  shed_w;
  logic [3:0]                  pair_w;
  logic [P_CW-1:0]             slot_w;
  logic [P_CW-1:0]             off_w [4];
  logic [3:0]                  pulse_w;
  logic [3:0]                  oe_w;
  logic [3:0]                  lvl_w;
  logic [3:0]                  park_w;

  mpps_lane_if #(.NCH(4)) lane ();

  // Count of set bits in a channel mask.
  function automatic logic [2:0] popc(input logic [3:0] m);
    popc = 3'h0;
    for (int k = 0; k < 4; k++) begin
      popc = popc + {2'h0, m[k]};
    end
  endfunction

  // Every pin level passes two flip-flops before use.
  mpps_sync #(.W(mpps_pkg::SYNC_W)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .i_d       ({i_load_step, i_fault, i_vcode_valid, i_por_ok, i_enable_term_rail,
                 i_enable_main_rail, i_phase_pin, i_ss_program_strap,
                 i_freq_program_strap, i_low_power_request_n}),
    .o_q       (s)
  );

  // Operational means supply good, both enables high and a valid voltage code.
  assign op_w   = s[mpps_pkg::SY_ENM] & s[mpps_pkg::SY_ENT] & s[mpps_pkg::SY_POR]
                & s[mpps_pkg::SY_VC];
  assign code_w = {s[mpps_pkg::SY_FS], s[mpps_pkg::SY_SS]};  // [R14]
  assign wrap   = (cnt_q == LAST);

  // Channel count from the phase straps and the low-power strap.
  always_comb begin
    logic [3:0] base;
    base = mpps_pkg::MASK_ALL;  // [R1]
    if (strap_q[1]) begin
      base = mpps_pkg::MASK_1;  // [R5]
    end else if (strap_q[2]) begin
      base = mpps_pkg::MASK_12;  // [R4]
    end else if (strap_q[3]) begin
      base = mpps_pkg::MASK_123;  // [R3]
    end
    pair_w = base[2] ? mpps_pkg::MASK_13 : (base & mpps_pkg::MASK_12);
    cfg_w  = base;
    if (lp_strap_q) begin
      cfg_w = code_w[0] ? pair_w : mpps_pkg::MASK_1;  // [R6]
    end
  end

  // Phases kept while low-power is asserted.
  always_comb begin
    unique case (code_w)
      mpps_pkg::LP_DROP1_UNC: shed_w = mpps_pkg::MASK_1;  // [R8]
      mpps_pkg::LP_DROP2_UNC: shed_w = pair_w & cfg_mask_q;
      mpps_pkg::LP_CI_DROP1:  shed_w = mpps_pkg::MASK_1;
      mpps_pkg::LP_CI_KEEP2:  shed_w = pair_w & cfg_mask_q;
    endcase
  end

  // Straps are caught once, on leaving the off state.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      strap_q    <= 4'h0;
      lp_strap_q <= 1'b0;
      cfg_mask_q <= mpps_pkg::MASK_NONE;
    end else if (i_clk_en && st_q == mpps_pkg::ST_OFF) begin
      strap_q    <= s[mpps_pkg::SY_PIN +: 4];  // [R16]
      lp_strap_q <= ~s[mpps_pkg::SY_LP];
      cfg_mask_q <= cfg_w;
    end
  end

  // Sequencer: loss of operation wins, then faults, then low-power changes.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q <= mpps_pkg::ST_OFF;
    end else if (i_clk_en) begin
      if (!op_w) begin
        st_q <= mpps_pkg::ST_OFF;
      end else begin
        unique case (st_q)
          mpps_pkg::ST_OFF: st_q <= mpps_pkg::ST_DELAY;
          mpps_pkg::ST_DELAY: begin
            if (s[mpps_pkg::SY_FLT]) begin
              st_q <= mpps_pkg::ST_FAULT;
            end else if (dly_q == DLAST) begin
              st_q <= mpps_pkg::ST_RUN;
            end
          end
          mpps_pkg::ST_RUN: begin
            if (s[mpps_pkg::SY_FLT]) begin
              st_q <= mpps_pkg::ST_FAULT;
            end else if (!s[mpps_pkg::SY_LP] && !lp_strap_q) begin
              st_q <= mpps_pkg::ST_SHED;  // [R8]
            end
          end
          mpps_pkg::ST_SHED: begin
            if (s[mpps_pkg::SY_FLT]) begin
              st_q <= mpps_pkg::ST_FAULT;
            end else if (s[mpps_pkg::SY_LP]) begin
              st_q <= mpps_pkg::ST_READD;  // [R9]
            end
          end
          mpps_pkg::ST_READD: begin
            if (s[mpps_pkg::SY_FLT]) begin
              st_q <= mpps_pkg::ST_FAULT;
            end else if (wrap) begin
              st_q <= mpps_pkg::ST_RUN;  // [R15]
            end
          end
          mpps_pkg::ST_FAULT: st_q <= mpps_pkg::ST_FAULT;
        endcase
      end
    end
  end

  // Start-up delay counter.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dly_q <= 32'h0;
    end else if (i_clk_en) begin
      dly_q <= (st_q == mpps_pkg::ST_DELAY) ? dly_q + 32'h1 : 32'h0;
    end
  end

  // Fixed-length switching period; channels take their timing from it.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (i_clk_en) begin
      if (st_q == mpps_pkg::ST_OFF || wrap) begin
        cnt_q <= '0;  // [R7]
      end else begin
        cnt_q <= cnt_q + P_CW'(1);
      end
    end
  end

  // Active set: drops at once, comes back at a period boundary when re-added, at once on a fault.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      run_mask_q <= mpps_pkg::MASK_NONE;
    end else if (i_clk_en) begin
      unique case (st_q)
        mpps_pkg::ST_OFF:   run_mask_q <= mpps_pkg::MASK_NONE;
        mpps_pkg::ST_SHED:  run_mask_q <= shed_w;
        mpps_pkg::ST_READD: run_mask_q <= wrap ? cfg_mask_q : run_mask_q;  // [R15]
        default:            run_mask_q <= cfg_mask_q;
      endcase
    end
  end

  // Slot spacing from the number of active channels.
  always_comb begin
    unique case (popc(run_mask_q))
      3'h2:    slot_w = SLOT2;
      3'h3:    slot_w = SLOT3;
      3'h4:    slot_w = SLOT4;
      default: slot_w = '0;
    endcase
  end

  // Per channel: offset by rank, then a dual-edge window around it.
  for (genvar i = 0; i < 4; i++) begin : g_ch
    logic [P_CW-1:0] rel;
    assign off_w[i] = P_CW'(P_CW'(popc(run_mask_q & ((4'h1 << i) - 4'h1))) * slot_w);  // [R2]
    assign rel = (cnt_q >= off_w[i]) ? cnt_q - off_w[i]
               : P_CW'({1'b0, cnt_q} + {1'b0, PER} - {1'b0, off_w[i]});
    // Trailing edge set by duty, leading edge pulled early by lead.
    assign pulse_w[i] = run_mask_q[i] & ((rel < i_duty) | (rel >= PER - i_lead)  // [R11]
                      | s[mpps_pkg::SY_STEP]);  // [R12]
  end

  // Lane requests: park, drive low or pulse, never on a strapped pin.
  always_comb begin
    oe_w   = 4'h0;
    lvl_w  = 4'h0;
    park_w = 4'h0;
    unique case (st_q)
      mpps_pkg::ST_OFF: park_w = 4'h0;
      mpps_pkg::ST_DELAY, mpps_pkg::ST_FAULT: park_w = cfg_mask_q;  // [R13]
      default: begin
        oe_w  = cfg_mask_q;  // [R16]
        lvl_w = pulse_w;
        if (!code_w[1] || lp_strap_q) begin
          park_w = cfg_mask_q & ~run_mask_q;  // [R10]
        end
      end
    endcase
  end

  assign lane.ce   = i_clk_en;
  assign lane.oe   = oe_w;
  assign lane.lvl  = lvl_w;
  assign lane.park = park_w;

  mpps_drv #(.NCH(4)) u_drv (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .lane      (lane.drv),
    .o_out     (o_phase_out),
    .o_oe      (o_phase_oe),
    .o_park    (o_phase_park)
  );

  // Status copy of the active set.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_active_mask <= 4'h0;
    end else if (i_clk_en) begin
      o_active_mask <= run_mask_q;
    end
  end

  // Re-add completes on the wrap that ends the waiting state.
  sequence s_readd_wrap;
    i_clk_en && st_q == mpps_pkg::ST_READD && wrap && op_w && !s[mpps_pkg::SY_FLT];
  endsequence

  a_default_four: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R1]
    (st_q == mpps_pkg::ST_DELAY && strap_q[3:1] == 3'h0 && !lp_strap_q)
      |-> cfg_mask_q == mpps_pkg::MASK_ALL)
    else $error("four channels not selected by default");
  a_quarter_spacing: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R2]
    run_mask_q == mpps_pkg::MASK_ALL
      |-> off_w[1] == SLOT4 && off_w[2] == P_CW'(2 * SLOT4) && off_w[3] == P_CW'(3 * SLOT4))
    else $error("four-channel spacing wrong");
  a_third_spacing: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R3]
    run_mask_q == mpps_pkg::MASK_123 |-> off_w[1] == SLOT3 && off_w[2] == P_CW'(2 * SLOT3))
    else $error("three-channel spacing wrong");
  a_half_spacing: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R4]
    run_mask_q == mpps_pkg::MASK_12 |-> off_w[1] == SLOT2)
    else $error("two-channel spacing wrong");
  a_single_undriven: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R5]
    (i_clk_en && st_q == mpps_pkg::ST_RUN && cfg_mask_q == mpps_pkg::MASK_1)
      |=> o_phase_oe[3:1] == 3'h0)
    else $error("unused phase pin driven");
  a_period_wrap: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R7]
    (i_clk_en && wrap) |=> cnt_q == '0)
    else $error("period did not wrap");
  a_shed_coupled_one: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R8]
    (i_clk_en && st_q == mpps_pkg::ST_SHED && code_w == mpps_pkg::LP_CI_DROP1)
      |=> run_mask_q == mpps_pkg::MASK_1)
    else $error("coupled drop to one phase missed");
  a_readd_done: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R9]
    s_readd_wrap |=> run_mask_q == cfg_mask_q && st_q == mpps_pkg::ST_RUN)
    else $error("phases not restored");
  a_readd_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R15]
    (i_clk_en && st_q == mpps_pkg::ST_READD && !wrap && op_w) |=> $stable(run_mask_q))
    else $error("phase re-added off the period boundary");
  a_load_step_all: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R12]
    (i_clk_en && st_q == mpps_pkg::ST_RUN && s[mpps_pkg::SY_STEP])
      |=> (o_phase_out & $past(run_mask_q)) == $past(run_mask_q))
    else $error("load step did not fire all phases");
  a_fault_park: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R13]
    (i_clk_en && st_q == mpps_pkg::ST_FAULT) |=> o_phase_park == $past(cfg_mask_q))
    else $error("phases not parked in fault");
  a_strap_undriven: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // [R16]
    (o_phase_oe & ~cfg_mask_q) == 4'h0)
    else $error("strapped pin driven");

endmodule

// file: design/mpps_pkg.sv
// Shared constants and types for the multiphase pulse sequencer.
package mpps_pkg;

  // Channel count and clock rate.
  localparam int NCH     = 4;
  localparam int CLK_MHZ = 100;

  // Switching frequency default and derived period in system clocks.
  localparam int FSW_KHZ    = 250;
  localparam int PERIOD_CYC = (CLK_MHZ * 1000) / FSW_KHZ;

  // Start-up delay before pulses are released, in microseconds and cycles.
  localparam int SS_DELAY_US  = 200;
  localparam int SS_DELAY_CYC = SS_DELAY_US * CLK_MHZ;

  // Bit positions inside the synchronised pin vector.
  localparam int SY_LP    = 0;
  localparam int SY_FS    = 1;
  localparam int SY_SS    = 2;
  localparam int SY_PIN   = 3;
  localparam int SY_ENM   = 7;
  localparam int SY_ENT   = 8;
  localparam int SY_POR   = 9;
  localparam int SY_VC    = 10;
  localparam int SY_FLT   = 11;
  localparam int SY_STEP  = 12;
  localparam int SYNC_W   = 13;

  // Low-power decode of {frequency strap, soft-start strap}.
  localparam logic [1:0] LP_DROP1_UNC = 2'h0;
  localparam logic [1:0] LP_DROP2_UNC = 2'h1;
  localparam logic [1:0] LP_CI_DROP1  = 2'h2;
  localparam logic [1:0] LP_CI_KEEP2  = 2'h3;

  // Channel masks, bit 0 is channel 1.
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_1    = 4'h1;
  localparam logic [3:0] MASK_12   = 4'h3;
  localparam logic [3:0] MASK_13   = 4'h5;
  localparam logic [3:0] MASK_123  = 4'h7;
  localparam logic [3:0] MASK_ALL  = 4'hF;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_OFF, ST_DELAY, ST_RUN, ST_SHED, ST_READD, ST_FAULT
  } mpps_state_type;

endpackage

// file: design/mpps_lane_if.sv
// Lane controls passed from the sequencer to the output stage.
`timescale 1ns/100ps
interface mpps_lane_if #(parameter int NCH = 4);
  logic           ce;
  logic [NCH-1:0] oe;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] park;
  modport seq (output ce, oe, lvl, park);
  modport drv (input ce, oe, lvl, park);
endinterface

// file: design/mpps_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
`timescale 1ns/100ps
module mpps_sync #(
  parameter int W = 1
) (
  // Clock, reset and enable.
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  input  wire logic         i_clk_en,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      o_q    <= '0;
    end else if (i_clk_en) begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule

// file: design/mpps_drv.sv
// Registered output stage for each phase pin.
`timescale 1ns/100ps
module mpps_drv #(
  parameter int NCH = 4
) (
  // Clock and reset.
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst,
  // Lane controls from the sequencer.
  mpps_lane_if.drv            lane,
  // Pin controls.
  output logic      [NCH-1:0] o_out,
  output logic      [NCH-1:0] o_oe,
  output logic      [NCH-1:0] o_park
);

  // Parking wins over driving so a lane never fights the mid-level bias.
  for (genvar i = 0; i < NCH; i++) begin : g_lane
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        o_out[i]  <= 1'b0;
        o_oe[i]   <= 1'b0;
        o_park[i] <= 1'b0;
      end else if (lane.ce) begin
        o_park[i] <= lane.park[i];
        o_oe[i]   <= lane.oe[i] & ~lane.park[i];
        o_out[i]  <= lane.lvl[i] & lane.oe[i] & ~lane.park[i];
      end
    end
  end

endmodule

// file: verification/mpps_fet_drv_model.sv
// Behavioural model of the external drivers that load and sense the phase pins.
`timescale 1ns/100ps
module mpps_fet_drv_model (
  // Clock and reset.
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Pin controls from the sequencer and board strap ties.
  input  wire logic [3:0] i_out,
  input  wire logic [3:0] i_oe,
  input  wire logic [3:0] i_park,
  input  wire logic [3:0] i_strap,
  // Sensed pin levels and a sticky contention flag.
  output logic      [3:0] o_sense,
  output logic            o_clash
);
  // A strap ties the pin to supply; a parked or released pin sits at the
  // divider level of the driver input, which the strap sensing reads as low.
  always_comb begin
    o_sense = i_strap | (i_oe & i_out);
  end

  // A driven strapped pin fights its tie, and a pin both driven and parked
  // leaves the driver with no defined command.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_clash <= 1'b0;
    end else if (((i_strap & i_oe) | (i_park & i_oe)) != 4'h0) begin
      o_clash <= 1'b1;
    end
  end
endmodule

// file: verification/mpps_top_tb_top.sv
// Self-checking bench for the phase sequencer with a cycle-level reference.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module mpps_top_tb_top;
  localparam int P = 12;
  logic        clk = 1'b0, rst = 1'b1, clk_en = 1'b1, lp_n = 1'b1, fs = 1'b0, ss = 1'b0;
  logic        enm = 1'b0, ent = 1'b0, por = 1'b0, vc = 1'b0, fault = 1'b0, step = 1'b0;
  logic [3:0]  strap = 4'h0, sense, out, oe, park, mask, hold;
  logic        clash;
  logic [15:0] duty = 16'h0004, lead = 16'h0000;
  int          n_fail = 0, checks = 0, seed = 32'h9A39BF0B, w;
  logic [3:0]  cfg [4] = '{4'hF, 4'h7, 4'h3, 4'h1};
  logic [3:0]  tie [4] = '{4'h0, 4'h8, 4'h4, 4'h2};

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  mpps_top #(.P_PERIOD(P), .P_SS_DELAY(20), .P_CW(16)) dut (
    .i_sys_clk(clk), .i_rst(rst), .i_clk_en(clk_en), .i_low_power_request_n(lp_n),
    .i_freq_program_strap(fs), .i_ss_program_strap(ss), .i_phase_pin(sense),
    .i_enable_main_rail(enm), .i_enable_term_rail(ent), .i_por_ok(por),
    .i_vcode_valid(vc), .i_fault(fault), .i_load_step(step), .i_duty(duty),
    .i_lead(lead), .o_phase_out(out), .o_phase_oe(oe), .o_phase_park(park),
    .o_active_mask(mask));

  mpps_fet_drv_model drv (
    .i_sys_clk(clk), .i_rst(rst), .i_out(out), .i_oe(oe), .i_park(park),
    .i_strap(strap), .o_sense(sense), .o_clash(clash));

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Resets, applies straps, raises the enables and waits for pulsing to begin.
  task automatic start(input logic [3:0] st, input logic l, f, s, input logic [3:0] em);
    int i;
    rst = 1'b1;
    {enm, ent, por, vc, fault, step} = 6'h00;
    tick(10);
    rst = 1'b0;
    strap = st;
    lp_n = l;
    fs = f;
    ss = s;
    tick(1);
    {enm, ent, por, vc} = 4'hF;
    tick(6);
    if (l) begin
      `CHK("delay park", em, park)
      `CHK("delay oe", 4'h0, oe)
    end
    for (i = 0; i < 60 && oe == 4'h0; i++) begin
      tick(1);
    end
  endtask

  // Reference: each active channel repeats every P clocks, is high for
  // duty+lead clocks, and sits rank*P/N clocks after the first channel.
  task automatic measure(input logic [3:0] em);
    int rq [4][$];
    int wd [4];
    int n, r, base, t, k;
    logic [3:0] pv;
    duty = 16'(1 + ($unsigned($random(seed)) % 5));
    lead = 16'($unsigned($random(seed)) % 3);
    w = int'(duty) + int'(lead);
    tick(P);
    `CHK("mask", em, mask)
    pv = out;
    for (t = 0; t < 3 * P; t++) begin
      tick(1);
      for (k = 0; k < 4; k++) begin
        if (out[k] && !pv[k]) rq[k].push_back(t);
        if (!out[k] && pv[k] && rq[k].size() > 0) wd[k] = t - rq[k][$];
      end
      pv = out;
    end
    n = $countones(em);
    r = 0;
    base = -1;
    for (k = 0; k < 4; k++) begin
      if (em[k]) begin
        `CHK("period", P, rq[k][1] - rq[k][0])
        `CHK("width", w, wd[k])
        if (base < 0) base = rq[k][0];
        else `CHK("spacing", r * P / n, (rq[k][0] - base + P) % P)
        r++;
      end else begin
        `CHK("idle pulses", 0, rq[k].size())
      end
    end
    // Contention is sticky but cleared by every reset, so look at it per scenario.
    `CHK("driver contention", 1'b0, clash)
  endtask

  // Main sequence.
  initial begin : main
    int c, i;
    logic [3:0] em, dr;
    // Channel count from output straps, load step, clock enable and fault park.
    for (c = 0; c < 4; c++) begin
      start(tie[c], 1'b1, 1'b0, 1'b0, cfg[c]);
      measure(cfg[c]);
      `CHK("oe set", cfg[c], oe)
      step = 1'b1;
      tick(4);
      `CHK("load step", cfg[c], out)
      step = 1'b0;
      clk_en = 1'b0;
      hold = out;
      tick(5);
      `CHK("frozen", hold, out)
      clk_en = 1'b1;
      fault = 1'b1;
      tick(6);
      fault = 1'b0;
      tick(6);
      `CHK("fault park", cfg[c], park)
      `CHK("fault oe", 4'h0, oe)
    end
    // Low-power drop for every strap decode, then re-add.
    for (c = 0; c < 4; c++) begin
      start(4'h0, 1'b1, c[1], c[0], 4'hF);
      lp_n = 1'b0;
      tick(8);
      em = c[0] ? 4'h5 : 4'h1;
      dr = 4'hF & ~em;
      `CHK("shed park", c[1] ? 4'h0 : dr, park & dr)
      `CHK("shed oe", c[1] ? dr : 4'h0, oe & dr)
      `CHK("shed out", 4'h0, out & dr)
      measure(em);
      lp_n = 1'b1;
      for (i = 0; i < P + 8 && mask != 4'hF; i++) begin
        tick(1);
      end
      `CHK("readd mask", 4'hF, mask)
      measure(4'hF);
    end
    // Low-power input strapped low at configuration.
    for (c = 0; c < 2; c++) begin
      em = c[0] ? 4'h5 : 4'h1;
      start(4'h0, 1'b0, 1'b0, c[0], em);
      measure(em);
      lp_n = 1'b1;
      tick(8);
      `CHK("static low power", em, mask)
      // Losing one enable or the supply good level leaves operation, so nothing is parked.
      if (c[0]) ent = 1'b0;
      else por = 1'b0;
      tick(4);
      `CHK("off park", 4'h0, park)
      `CHK("off oe", 4'h0, oe)
    end
    `CHK("driver contention", 1'b0, clash)
    summarize();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #300000;
    n_fail++;
    summarize();
  end
endmodule
